// File: hw/timer_counter_pkg.sv
// Constants, layouts and types for the standard timer/counter block.
// Assumes hclk is the oscillator clock and all pins are synchronous to it.
package timer_counter_pkg;

	// Oscillator periods per timer tick and per count-pin sample
	localparam logic [3:0] tick_div = 4'hc;

	// Register indices; byte address is four times the index
	localparam logic [7:0] idx_timer_control       = 8'h88;
	localparam logic [7:0] idx_timer_mode_register = 8'h89;
	localparam logic [7:0] idx_timer0_count_low    = 8'h8a;
	localparam logic [7:0] idx_timer1_count_low    = 8'h8b;
	localparam logic [7:0] idx_timer0_count_high   = 8'h8c;
	localparam logic [7:0] idx_timer1_count_high   = 8'h8d;
	localparam logic [7:0] idx_timer2_setup        = 8'hc8;
	localparam logic [7:0] idx_timer2_capture_low  = 8'hca;
	localparam logic [7:0] idx_timer2_capture_high = 8'hcb;
	localparam logic [7:0] idx_timer2_count_low    = 8'hcc;
	localparam logic [7:0] idx_timer2_count_high   = 8'hcd;
	localparam logic [7:0] idx_irq_status          = 8'hf0;
	localparam logic [7:0] idx_irq_mask            = 8'hf1;

	// Field positions in timer_control
	localparam int timer1_overflow_flag_bit  = 7;
	localparam int timer1_run_bit            = 6;
	localparam int timer0_overflow_flag_bit  = 5;
	localparam int timer0_run_bit            = 4;
	localparam int ext_int1_flag_bit         = 3;
	localparam int ext_int1_trigger_type_bit = 2;
	localparam int ext_int0_flag_bit         = 1;
	localparam int ext_int0_trigger_type_bit = 0;

	// Field positions in timer2_setup
	localparam int timer2_overflow_flag_bit = 7;
	localparam int timer2_counter_fn_bit    = 1;
	localparam int timer2_run_bit           = 0;

	// Event order in service_ack and irq_status
	localparam int ev_ext_int0 = 0;
	localparam int ev_timer0   = 1;
	localparam int ev_ext_int1 = 2;
	localparam int ev_timer1   = 3;
	localparam int ev_timer2   = 4;

	// Reset values
	localparam logic [7:0] timer_control_reset = 8'h00;
	localparam logic [7:0] timer_mode_reset    = 8'h00;
	localparam logic [7:0] count_reset         = 8'h00;
	localparam logic [4:0] irq_reset           = 5'h00;

	// Timer mode field codes
	localparam logic [1:0] mode_13bit  = 2'h0;
	localparam logic [1:0] mode_16bit  = 2'h1;
	localparam logic [1:0] mode_reload = 2'h2;
	localparam logic [1:0] mode_split  = 2'h3;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} count_s;

	typedef struct packed {
		logic   ovf;
		count_s cnt;
	} step_s;

	typedef struct packed {
		logic       gate;
		logic       counter_fn;
		logic [1:0] mode;
	} mode_s;

	typedef enum logic [1:0] {
		bus_idle = 2'b01,
		bus_read = 2'b10
	} bus_state_e;

endpackage : timer_counter_pkg

// File: hw/standard_timer_counters.sv
// Three 16-bit timer/counters with shared control, as an AHB-Lite slave.
// Assumes hclk is the oscillator clock; count and interrupt pins are
// synchronous to hclk; service_ack pulses when firmware services a source.
//
// How it works
// (R01) Three 16-bit timer/counters, timer or counter
// (R02) Timer function counts once per twelve periods
// (R03) Tick comes from oscillator, no core effects
// (R04) Counter function counts falling edges of own pin
// (R05) Sample every tick; count one tick after fall
// (R06) Source holds each level one sample period
// (R07) Divided core clock needs longer pin levels
// (R08) Timer 1 overflow sets bit 7, service clears
// (R09) Timer 0 overflow sets bit 5, service clears
// (R10) Bit 6 runs timer 1
// (R11) Bit 4 runs timer 0
// (R12) Int pin 1 active sets bit 3, service clears
// (R13) Int pin 0 active sets bit 1, service clears
// (R14) Bit 2 picks edge or level for pin 1
// (R15) Bit 0 picks edge or level for pin 0
// (R16) Mode field: 13-bit, 16-bit, reload, stop/split
// (R17) Gate bit makes interrupt pin high also required
// (R18) Reload mode reloads low byte from high byte
// (R19) One divide-by-twelve tick for counts and samples
//
// Chosen here: the AHB-Lite register port.
module standard_timer_counters
	import timer_counter_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        timer0_count_pin,
	input  wire logic        timer1_count_pin,
	input  wire logic        timer2_count_pin,
	input  wire logic        external_interrupt_pin_0,
	input  wire logic        external_interrupt_pin_1,
	input  wire logic [4:0]  service_ack,
	output logic [4:0]       int_request,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	// One increment step of a timer in the given mode
	function automatic step_s timer_step(
		input logic [1:0] mode,
		input count_s     cur,
		input logic       inc
	);
		step_s r;
		logic [5:0] lo5;
		logic [8:0] hi9;
		logic [16:0] w17;
		r = {1'b0, cur};
		lo5 = {1'b0, cur.lo[4:0]} + 6'h01;
		hi9 = {1'b0, cur.hi} + 9'h001;
		w17 = {1'b0, cur} + 17'h0_0001;
		if (inc) begin
			case (mode) // [R16]
				mode_13bit: begin
					r.cnt.lo[4:0] = lo5[4:0];
					if (lo5[5]) begin
						r.cnt.hi = hi9[7:0];
						r.ovf    = hi9[8];
					end
				end
				mode_16bit: begin
					r.cnt = w17[15:0];
					r.ovf = w17[16];
				end
				mode_reload: begin
					if (cur.lo == 8'hff) begin
						r.cnt.lo = cur.hi; // [R18]
						r.ovf    = 1'b1; // [R18]
					end else begin
						r.cnt.lo = cur.lo + 8'h01;
					end
				end
				mode_split: begin
					r.cnt.lo = cur.lo + 8'h01;
					r.ovf    = (cur.lo == 8'hff);
				end
				default: begin
					r = {1'b0, cur};
				end
			endcase
		end
		return r;
	endfunction : timer_step

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0]  timer_control;
	mode_s       mode0;
	mode_s       mode1;
	count_s      count0;
	count_s      count1;
	count_s      count2;
	count_s      capture2;
	logic        timer2_run;
	logic        timer2_counter_fn;
	logic        timer2_overflow_flag;
	logic [4:0]  irq_status;
	logic [4:0]  irq_mask;

	logic [3:0]  tick_cnt;
	logic        tick;
	logic [2:0]  sample_now;
	logic [2:0]  sample_prev;
	logic        ext0_prev;
	logic        ext1_prev;

	bus_state_e  bus_state;
	logic        wr_pending;
	logic [7:0]  wr_idx;
	logic [7:0]  rd_idx;
	logic [7:0]  rd_value;

	////////////////////////////////////////////////////////////////////////
	// Tick prescaler, fed from hclk only so core stalls cannot slow it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt <= 4'h0;
			tick     <= 1'b0;
		end else begin
			if (tick_cnt == tick_div - 4'h1) begin // [R19] [R03]
				tick_cnt <= 4'h0;
				tick     <= 1'b1; // [R02]
			end else begin
				tick_cnt <= tick_cnt + 4'h1;
				tick     <= 1'b0;
			end
		end
	end

	// Count pins sampled once per tick; pulse lasts too short is missed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample_now  <= 3'h0;
			sample_prev <= 3'h0;
		end else if (tick) begin
			sample_now  <= {timer2_count_pin, timer1_count_pin,
				timer0_count_pin}; // [R05] [R19]
			sample_prev <= sample_now;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Count enables
	logic [2:0] pin_inc;
	logic       run0;
	logic       run1;
	logic       en0;
	logic       en1;
	logic       inc0;
	logic       inc1;
	logic       inc2;
	logic       t0_split;
	logic       th0_inc;
	logic [8:0] th0_next;
	step_s      step0;
	step_s      step1;
	step_s      step2;

	// Fall seen across two samples counts on the following tick
	assign pin_inc = {3{tick}} & sample_prev & ~sample_now; // [R04] [R05]
	assign run0    = timer_control[timer0_run_bit]; // [R11]
	assign run1    = timer_control[timer1_run_bit]; // [R10]
	assign en0     = run0 & (~mode0.gate | external_interrupt_pin_0); // [R17]
	assign en1     = run1 & (~mode1.gate | external_interrupt_pin_1); // [R17]
	assign inc0    = en0 & (mode0.counter_fn ? pin_inc[0] : tick); // [R01]
	assign inc1    = en1 & (mode1.mode != mode_split)
		& (mode1.counter_fn ? pin_inc[1] : tick); // [R16]
	assign inc2    = timer2_run
		& (timer2_counter_fn ? pin_inc[2] : tick); // [R01]
	assign t0_split = (mode0.mode == mode_split);
	// In split mode the high byte of timer 0 borrows timer 1 run and flag
	assign th0_inc  = t0_split & run1 & tick;
	assign th0_next = {1'b0, count0.hi} + 9'h001;
	assign step0    = timer_step(mode0.mode, count0, inc0);
	assign step1    = timer_step(mode1.mode, count1, inc1);
	assign step2    = timer_step(mode_16bit, count2, inc2);

	////////////////////////////////////////////////////////////////////////
	// Software writes, taken in the data phase
	function automatic logic wr_hit(
		input logic       pend,
		input logic [7:0] idx,
		input logic [7:0] target
	);
		return pend & (idx == target);
	endfunction : wr_hit

	logic [7:0] wd;
	assign wd = hwdata[7:0];

	// Software write wins over a count step in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count0 <= {count_reset, count_reset};
			count1 <= {count_reset, count_reset};
			count2 <= {count_reset, count_reset};
		end else begin
			count0.lo <= wr_hit(wr_pending, wr_idx, idx_timer0_count_low)
				? wd : step0.cnt.lo;
			if (wr_hit(wr_pending, wr_idx, idx_timer0_count_high)) begin
				count0.hi <= wd;
			end else if (th0_inc) begin
				count0.hi <= th0_next[7:0];
			end else if (!t0_split) begin
				count0.hi <= step0.cnt.hi;
			end
			count1.lo <= wr_hit(wr_pending, wr_idx, idx_timer1_count_low)
				? wd : step1.cnt.lo;
			count1.hi <= wr_hit(wr_pending, wr_idx, idx_timer1_count_high)
				? wd : step1.cnt.hi;
			count2.lo <= wr_hit(wr_pending, wr_idx, idx_timer2_count_low)
				? wd : (step2.ovf ? capture2.lo : step2.cnt.lo);
			count2.hi <= wr_hit(wr_pending, wr_idx, idx_timer2_count_high)
				? wd : (step2.ovf ? capture2.hi : step2.cnt.hi);
		end
	end

	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode0             <= timer_mode_reset[3:0];
			mode1             <= timer_mode_reset[7:4];
			capture2          <= {count_reset, count_reset};
			timer2_run        <= 1'b0;
			timer2_counter_fn <= 1'b0;
			irq_mask          <= irq_reset;
		end else begin
			if (wr_hit(wr_pending, wr_idx, idx_timer_mode_register)) begin
				mode0 <= wd[3:0]; // [R16]
				mode1 <= wd[7:4]; // [R16]
			end
			if (wr_hit(wr_pending, wr_idx, idx_timer2_capture_low)) begin
				capture2.lo <= wd;
			end
			if (wr_hit(wr_pending, wr_idx, idx_timer2_capture_high)) begin
				capture2.hi <= wd;
			end
			if (wr_hit(wr_pending, wr_idx, idx_timer2_setup)) begin
				timer2_run        <= wd[timer2_run_bit];
				timer2_counter_fn <= wd[timer2_counter_fn_bit];
			end
			if (wr_hit(wr_pending, wr_idx, idx_irq_mask)) begin
				irq_mask <= wd[4:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flags: hardware set wins over a service clear in the same cycle
	logic [4:0] ev;
	logic       ext0_active;
	logic       ext1_active;

	assign ext0_active = timer_control[ext_int0_trigger_type_bit]
		? (ext0_prev & ~external_interrupt_pin_0)
		: ~external_interrupt_pin_0; // [R15]
	assign ext1_active = timer_control[ext_int1_trigger_type_bit]
		? (ext1_prev & ~external_interrupt_pin_1)
		: ~external_interrupt_pin_1; // [R14]
	assign ev[ev_ext_int0] = ext0_active;
	assign ev[ev_timer0]   = step0.ovf;
	assign ev[ev_ext_int1] = ext1_active;
	assign ev[ev_timer1]   = t0_split ? (th0_inc & th0_next[8]) : step1.ovf;
	assign ev[ev_timer2]   = step2.ovf;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext0_prev <= 1'b1;
			ext1_prev <= 1'b1;
		end else begin
			ext0_prev <= external_interrupt_pin_0;
			ext1_prev <= external_interrupt_pin_1;
		end
	end

	function automatic logic flag_next(
		input logic cur,
		input logic set,
		input logic clr
	);
		return set | (cur & ~clr);
	endfunction : flag_next

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_control        <= timer_control_reset;
			timer2_overflow_flag <= 1'b0;
		end else begin
			timer_control[timer1_overflow_flag_bit] <= flag_next(
				timer_control[timer1_overflow_flag_bit],
				ev[ev_timer1], service_ack[ev_timer1]); // [R08]
			timer_control[timer0_overflow_flag_bit] <= flag_next(
				timer_control[timer0_overflow_flag_bit],
				ev[ev_timer0], service_ack[ev_timer0]); // [R09]
			timer_control[ext_int1_flag_bit] <= flag_next(
				timer_control[ext_int1_flag_bit],
				ev[ev_ext_int1], service_ack[ev_ext_int1]); // [R12]
			timer_control[ext_int0_flag_bit] <= flag_next(
				timer_control[ext_int0_flag_bit],
				ev[ev_ext_int0], service_ack[ev_ext_int0]); // [R13]
			timer2_overflow_flag <= flag_next(timer2_overflow_flag,
				ev[ev_timer2], service_ack[ev_timer2]);
			if (wr_hit(wr_pending, wr_idx, idx_timer_control)) begin
				timer_control[timer1_run_bit]  <= wd[timer1_run_bit]; // [R10]
				timer_control[timer0_run_bit]  <= wd[timer0_run_bit]; // [R11]
				timer_control[ext_int1_trigger_type_bit] <=
					wd[ext_int1_trigger_type_bit]; // [R14]
				timer_control[ext_int0_trigger_type_bit] <=
					wd[ext_int0_trigger_type_bit]; // [R15]
			end
		end
	end

	// Sticky status, write one to clear; new event beats the clear
	logic [4:0] w1c;
	assign w1c = wr_hit(wr_pending, wr_idx, idx_irq_status)
		? wd[4:0] : 5'h00;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status  <= irq_reset;
			irq         <= 1'b0;
			int_request <= irq_reset;
		end else begin
			irq_status  <= ev | (irq_status & ~w1c);
			irq         <= |(irq_status & irq_mask);
			int_request <= {timer2_overflow_flag,
				timer_control[timer1_overflow_flag_bit],
				timer_control[ext_int1_flag_bit],
				timer_control[timer0_overflow_flag_bit],
				timer_control[ext_int0_flag_bit]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped indices read zero
	always_comb begin
		case (rd_idx)
			idx_timer_control:       rd_value = timer_control;
			idx_timer_mode_register: rd_value = {mode1, mode0};
			idx_timer0_count_low:    rd_value = count0.lo;
			idx_timer1_count_low:    rd_value = count1.lo;
			idx_timer0_count_high:   rd_value = count0.hi;
			idx_timer1_count_high:   rd_value = count1.hi;
			idx_timer2_setup:        rd_value = {timer2_overflow_flag,
				5'h00, timer2_counter_fn, timer2_run};
			idx_timer2_capture_low:  rd_value = capture2.lo;
			idx_timer2_capture_high: rd_value = capture2.hi;
			idx_timer2_count_low:    rd_value = count2.lo;
			idx_timer2_count_high:   rd_value = count2.hi;
			idx_irq_status:          rd_value = {3'h0, irq_status};
			idx_irq_mask:            rd_value = {3'h0, irq_mask};
			default:                 rd_value = 8'h00;
		endcase
	end

	// AHB-Lite: writes zero wait; reads one wait so the data is registered
	// after any write ahead of them has landed
	logic       take;
	logic [7:0] a_idx;
	assign take  = hsel & htrans[1] & hready;
	assign a_idx = haddr[9:2];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state  <= bus_idle;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			hrdata     <= 32'h0000_0000;
			wr_pending <= 1'b0;
			wr_idx     <= 8'h00;
			rd_idx     <= 8'h00;
		end else begin
			hresp <= 1'b0;
			case (bus_state)
				bus_idle: begin
					wr_pending <= take & hwrite & (haddr[31:10] == 22'h0);
					wr_idx     <= a_idx;
					if (take && !hwrite) begin
						rd_idx    <= (haddr[31:10] == 22'h0) ? a_idx : 8'h00;
						hreadyout <= 1'b0;
						bus_state <= bus_read;
					end
				end
				bus_read: begin
					wr_pending <= 1'b0;
					hrdata     <= {24'h00_0000, rd_value};
					hreadyout  <= 1'b1;
					bus_state  <= bus_idle;
				end
				default: begin
					wr_pending <= 1'b0;
					hreadyout  <= 1'b1;
					bus_state  <= bus_idle;
				end
			endcase
		end
	end

endmodule : standard_timer_counters

// File: dv/timer_counter_monitor.sv
// Assertion checker for the timer/counter block, bound to its ports.
// Assumes a single hclk domain with hresetn as its async reset.
module timer_counter_monitor
	import timer_counter_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        external_interrupt_pin_0,
	input wire logic        external_interrupt_pin_1,
	input wire logic [4:0]  service_ack,
	input wire logic [4:0]  int_request
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic taken;
	assign taken = hsel && htrans[1] && hready;
	////////////////////////////////////////////////////////////////
	// Six samples leave room for a pin synchroniser
	sequence s_low0;
		$fell(external_interrupt_pin_0) ##0
			(!external_interrupt_pin_0 && !service_ack[ev_ext_int0])[*6];
	endsequence
	sequence s_low1;
		$fell(external_interrupt_pin_1) ##0
			(!external_interrupt_pin_1 && !service_ack[ev_ext_int1])[*6];
	endsequence
	sequence s_read;
		taken && !hwrite;
	endsequence
	a_read_wait: assert property (s_read |=> !hreadyout ##1 hreadyout)
		else $error("Read wait state wrong");
	a_write_fast: assert property (taken && hwrite |=> hreadyout)
		else $error("Write stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("Response not OKAY");
	a_rdata_byte: assert property (hrdata[31:8] == 24'h00_0000)
		else $error("Upper read data not zero");
	a_ext0_sets: assert property (s_low0 |-> int_request[ev_ext_int0])
		else $error("Ext int 0 flag not set");
	a_ext1_sets: assert property (s_low1 |-> int_request[ev_ext_int1])
		else $error("Ext int 1 flag not set");
	a_t0_clear: assert property (
		$fell(int_request[ev_timer0]) |-> $past(service_ack[ev_timer0], 2))
		else $error("Timer 0 flag cleared without service");
	a_t1_clear: assert property (
		$fell(int_request[ev_timer1]) |-> $past(service_ack[ev_timer1], 2))
		else $error("Timer 1 flag cleared without service");
endmodule : timer_counter_monitor

bind standard_timer_counters timer_counter_monitor timer_counter_monitor_i (
	.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
	.hrdata, .external_interrupt_pin_0, .external_interrupt_pin_1,
	.service_ack, .int_request
);

// File: dv/pin_source.sv
// Model of the sources that drive the three count pins.
// Assumes hclk is the oscillator clock; start pulses come from the bench.
module pin_source
	import timer_counter_pkg::*;
(
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic [2:0] start,
	output logic [2:0]     pins,
	output logic           busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] left [3];
	////////////////////////////////////////////////////////////////
	// One pulse: low for two sample periods, then high for two
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left <= '{default: 6'h00};
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (left[i] != 6'h00)
					left[i] <= left[i] - 6'h01;
				else if (start[i])
					left[i] <= {tick_div, 2'b00};
			end
		end
	end
	// Levels last two ticks so no level slips between samples
	always_comb begin
		for (int i = 0; i < 3; i++)
			pins[i] = (left[i] <= {1'b0, tick_div, 1'b0});
	end
	assign busy = |{left[0], left[1], left[2]};
endmodule : pin_source

// File: dv/test_standard_timer_counters.sv
// Self-checking bench for the standard timer/counter block.
// Assumes it is the only AHB-Lite master; pin_source drives count pins.
module test_standard_timer_counters
	import timer_counter_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 1'b0, hresetn = 1'b0;
	logic        hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  start = 3'h0;
	logic        ext0 = 1'b1, ext1 = 1'b1;
	logic [4:0]  service_ack = 5'h00;
	logic        hreadyout, hresp, busy, irq;
	logic [31:0] hrdata, d;
	logic [2:0]  pins;
	logic [4:0]  int_request;
	int          n_fail = 0, samples_checked = 0, cycles = 0;

	standard_timer_counters standard_timer_counters_i (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.timer0_count_pin(pins[0]), .timer1_count_pin(pins[1]),
		.timer2_count_pin(pins[2]), .external_interrupt_pin_0(ext0),
		.external_interrupt_pin_1(ext1), .service_ack, .int_request, .irq
	);
	pin_source pin_source_i (.hclk, .hresetn, .start, .pins, .busy);

	initial begin
		forever #12.5 hclk = ~hclk;
	end
	// The whole run needs about 1000 cycles
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Single transfer; waits on hready, never on a cycle count
	task automatic xfer(input logic [7:0] idx, input logic wr,
		input logic [7:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : xfer
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		xfer(idx, 1'b1, wd);
	endtask : wr
	task automatic rd(input string name, input logic [7:0] idx,
		input logic [31:0] exp);
		xfer(idx, 1'b0, 8'h00);
		check(name, d, exp);
	endtask : rd
	task automatic ack(input int ev);
		@(posedge hclk);
		service_ack[ev] <= 1'b1;
		@(posedge hclk);
		service_ack <= 5'h00;
	endtask : ack
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd("control reset", idx_timer_control, 32'h0000_0000);
		wr(idx_timer_control, 8'hff);
		rd("control bits", idx_timer_control, 32'h0000_0055);
		wr(idx_timer_control, 8'h00);
		wr(8'h10, 8'hff);
		rd("unmapped", 8'h10, 32'h0000_0000);
	endtask : t_regs
	task automatic t_reload(input int t);
		int n;
		int ev, rb, fb;
		logic [7:0] lo, hi;
		logic [31:0] v;
		lo = t ? idx_timer1_count_low : idx_timer0_count_low;
		hi = t ? idx_timer1_count_high : idx_timer0_count_high;
		ev = t ? ev_timer1 : ev_timer0;
		rb = t ? timer1_run_bit : timer0_run_bit;
		fb = t ? timer1_overflow_flag_bit : timer0_overflow_flag_bit;
		wr(idx_timer_mode_register, 8'h22);
		wr(hi, 8'hfe);
		wr(lo, 8'hfe);
		wr(idx_timer_control, 8'h01 << rb);
		do @(posedge hclk); while (int_request[ev] !== 1'b1);
		service_ack[ev] <= 1'b1;
		@(posedge hclk);
		service_ack <= 5'h00;
		n = 1;
		do begin
			@(posedge hclk);
			n++;
		end while (int_request[ev] !== 1'b0);
		do begin
			@(posedge hclk);
			n++;
		end while (int_request[ev] !== 1'b1);
		check("overflow spacing", n, 2 * tick_div);
		wr(idx_timer_control, 8'h00);
		rd("flag set", idx_timer_control, 32'h1 << fb);
		rd("reload keeps high", hi, 32'h0000_00fe);
		xfer(lo, 1'b0, 8'h00);
		v = d;
		repeat (40) @(posedge hclk);
		rd("run off holds", lo, v);
		ack(ev);
		rd("flag served", idx_timer_control, 32'h0000_0000);
	endtask : t_reload
	task automatic t_irq();
		rd("status sticky", idx_irq_status, 32'h0000_000a);
		check("irq masked", irq, 1'b0);
		wr(idx_irq_mask, 8'h02);
		repeat (2) @(posedge hclk);
		check("irq raised", irq, 1'b1);
		wr(idx_irq_status, 8'h02);
		repeat (2) @(posedge hclk);
		check("irq cleared", irq, 1'b0);
		rd("status cleared", idx_irq_status, 32'h0000_0008);
		wr(idx_irq_mask, 8'h00);
	endtask : t_irq
	// Pin i gets i+1 falls, so a crossed pin shows up
	task automatic t_count();
		wr(idx_timer_mode_register, 8'h55);
		wr(idx_timer2_setup, 8'h03);
		wr(idx_timer0_count_low, 8'h00);
		wr(idx_timer1_count_low, 8'h00);
		wr(idx_timer2_count_low, 8'h00);
		wr(idx_timer_control, 8'h50);
		for (int k = 0; k < 3; k++) begin
			@(posedge hclk);
			start <= 3'b111 << k;
			@(posedge hclk);
			start <= 3'b000;
			do @(posedge hclk); while (busy !== 1'b0);
		end
		repeat (30) @(posedge hclk);
		wr(idx_timer_control, 8'h00);
		wr(idx_timer2_setup, 8'h00);
		rd("pin 0 count", idx_timer0_count_low, 32'h1);
		rd("pin 1 count", idx_timer1_count_low, 32'h2);
		rd("pin 2 count", idx_timer2_count_low, 32'h3);
	endtask : t_count
	task automatic t_gate();
		wr(idx_timer_mode_register, 8'h09);
		wr(idx_timer0_count_low, 8'h00);
		ext0 <= 1'b0;
		wr(idx_timer_control, 8'h10);
		repeat (60) @(posedge hclk);
		rd("gate holds", idx_timer0_count_low, 32'h0);
		ext0 <= 1'b1;
		repeat (60) @(posedge hclk);
		wr(idx_timer_control, 8'h00);
		xfer(idx_timer0_count_low, 1'b0, 8'h00);
		check("gate opens", d != 0, 1'b1);
		ack(ev_ext_int0);
	endtask : t_gate
	task automatic t_ext();
		logic [7:0] tb;
		for (int p = 0; p < 2; p++) begin
			for (int m = 0; m < 2; m++) begin
				tb = 8'(m << (2 * p));
				wr(idx_timer_control, tb);
				if (p == 1) ext1 <= 1'b0;
				else ext0 <= 1'b0;
				repeat (4) @(posedge hclk);
				rd("ext set", idx_timer_control, tb | 2 << 2 * p);
				ack(p ? ev_ext_int1 : ev_ext_int0);
				rd("ext low", idx_timer_control,
					tb | (1 - m) << (2 * p + 1));
				if (p == 1) ext1 <= 1'b1;
				else ext0 <= 1'b1;
				ack(p ? ev_ext_int1 : ev_ext_int0);
				rd("ext served", idx_timer_control, tb);
			end
		end
	endtask : t_ext
	task automatic t_modes();
		wr(idx_timer_mode_register, 8'h30);
		wr(idx_timer0_count_low, 8'hff);
		wr(idx_timer0_count_high, 8'hff);
		wr(idx_timer1_count_low, 8'h00);
		wr(idx_timer_control, 8'h50);
		repeat (40) @(posedge hclk);
		wr(idx_timer_control, 8'h00);
		rd("mode 0 wraps", idx_timer0_count_high, 32'h0);
		xfer(idx_timer0_count_low, 1'b0, 8'h00);
		check("mode 0 top bits", d[7:5], 3'h7);
		rd("mode 3 stopped", idx_timer1_count_low, 32'h0);
		check("mode 0 overflow", int_request[ev_timer0], 1'b1);
		ack(ev_timer0);
		// Split timer 0: its high byte runs on timer 1 run and flag
		wr(idx_timer_mode_register, 8'h33);
		wr(idx_timer0_count_high, 8'hff);
		wr(idx_timer_control, 8'h40);
		repeat (20) @(posedge hclk);
		wr(idx_timer_control, 8'h00);
		rd("split high flag", idx_timer_control, 32'h0000_0080);
		ack(ev_timer1);
		rd("split flag served", idx_timer_control, 32'h0000_0000);
	endtask : t_modes
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_reload(0);
		t_reload(1);
		t_irq();
		t_count();
		t_gate();
		t_ext();
		t_modes();
		test_done();
	end
endmodule : test_standard_timer_counters
